// ==== core/eps_pkg.sv ====
// Package with register map, field layout, reset values and timing for the PHY select block
package eps_pkg;

	// Register byte offsets
	localparam logic [11:0] OFS_PHY_CFG  = 12'h000;
	localparam logic [11:0] OFS_MAC_RST  = 12'h004;
	localparam logic [11:0] OFS_PHY_CR1  = 12'h008;
	localparam logic [11:0] OFS_PHY_CR2  = 12'h00C;
	localparam logic [11:0] OFS_PHY_CR3  = 12'h010;
	localparam logic [11:0] OFS_PHY_SEL  = 12'h014;
	localparam logic [11:0] OFS_LPI_TMR  = 12'h018;
	localparam logic [11:0] OFS_LPI_CS   = 12'h01C;
	localparam logic [11:0] OFS_NUM_ADDR = 12'h020;

	// Selection codes
	localparam logic [1:0] PHY_SEL_ON_CHIP  = 2'h0;
	localparam logic [1:0] PHY_SEL_EXT_MII  = 2'h1;
	localparam logic [1:0] PHY_SEL_EXT_RMII = 2'h2;

	// Configuration word layout
	localparam int unsigned CF_SEL_LO    = 0;
	localparam int unsigned CF_HOLD      = 2;
	localparam int unsigned CF_NIB_DIS   = 3;
	localparam int unsigned CF_RXER_IDLE = 4;
	localparam int unsigned CF_ISOLATE   = 5;
	localparam int unsigned CF_EXT_FD    = 6;
	localparam int unsigned CF_FAST_LUP  = 7;
	localparam int unsigned CF_LLR       = 8;
	localparam int unsigned CF_TDR       = 9;
	localparam int unsigned CF_ROB_MDIX  = 10;
	localparam int unsigned CF_FAST_MDIX = 11;
	localparam int unsigned CF_MDIX_EN   = 12;
	localparam int unsigned CF_FAST_RXDV = 13;
	localparam int unsigned CF_FAN_LO    = 14;
	localparam int unsigned CF_SPD_LO    = 17;
	localparam int unsigned CF_LD_RXERR  = 20;
	localparam int unsigned CF_LD_SQE    = 21;
	localparam int unsigned CF_LD_SNR    = 22;
	localparam int unsigned CF_LD_ENERGY = 23;
	localparam int unsigned CF_POL_SWAP  = 24;
	localparam int unsigned CF_PAIR_SWAP = 25;

	// PHY control register bit positions
	localparam int unsigned R1_FAST_RXDV = 1;
	localparam int unsigned R1_FAN_LO    = 2;
	localparam int unsigned R1_ROB_MDIX  = 5;
	localparam int unsigned R1_FAST_MDIX = 6;
	localparam int unsigned R1_LLR       = 7;
	localparam int unsigned R1_TDR       = 8;
	localparam int unsigned R1_SPD_LO    = 11;
	localparam int unsigned R1_MDIX_EN   = 14;
	localparam int unsigned R2_NIB_DIS   = 1;
	localparam int unsigned R2_RXER_IDLE = 2;
	localparam int unsigned R2_ISOLATE   = 3;
	localparam int unsigned R2_EXT_FD    = 5;
	localparam int unsigned R2_FAST_LUP  = 6;
	localparam int unsigned R3_LD_ENERGY = 0;
	localparam int unsigned R3_LD_SNR    = 1;
	localparam int unsigned R3_LD_SQE    = 2;
	localparam int unsigned R3_LD_RXERR  = 3;
	localparam int unsigned R3_POL_SWAP  = 5;
	localparam int unsigned R3_PAIR_SWAP = 6;

	// Low-power-idle control and status layout
	localparam int unsigned LS_TX_ENTER = 0;
	localparam int unsigned LS_TX_EXIT  = 1;
	localparam int unsigned LS_RX_ENTER = 2;
	localparam int unsigned LS_RX_EXIT  = 3;
	localparam int unsigned LS_TX_IN    = 8;
	localparam int unsigned LS_RX_IN    = 9;
	localparam int unsigned LC_ENTER    = 16;
	localparam int unsigned LC_LINK     = 17;
	localparam int unsigned LC_AUTOMATE = 19;

	// Reset values
	localparam logic [31:0] CFG_RST      = 32'h0000_0000;
	localparam logic [15:0] LS_TMR_RST   = 16'h03E8;
	localparam logic [15:0] TW_TMR_RST   = 16'h0000;
	localparam logic [3:0]  NUM_ADDR_DEF = 4'h4;
	localparam logic [3:0]  MAC_RST_LEN  = 4'h8;

	// Timing
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned US_NS         = 1000;
	localparam int unsigned MS_NS         = 1000000;
	localparam int unsigned US_CYC        = US_NS / CLK_PERIOD_NS;
	localparam int unsigned MS_CYC        = MS_NS / CLK_PERIOD_NS;

	// Transmit low-power-idle states
	typedef enum logic [1:0] {
		EPS_TX_ACTIVE = 2'b00,
		EPS_TX_LPI    = 2'b01,
		EPS_TX_WAKE   = 2'b10
	} eps_tx_t;

endpackage : eps_pkg

// ==== core/eps_tmr.sv ====
// Down-counting timer in whole units of a fixed number of clock cycles
`timescale 1ns/100ps
module eps_tmr #(
	parameter int unsigned TICK_CYC = 250
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	// Control
	input  wire logic        start_i,
	input  wire logic [15:0] value_i,
	// Status
	output logic             done_o
);

	// Timer state
	typedef struct packed {
		logic        run;
		logic [31:0] pre;
		logic [15:0] cnt;
		logic        done;
	} eps_tmr_st_t;

	eps_tmr_st_t q, d;

	// Prescale to units, then count units down
	always_comb begin
		d = q;
		if (start_i) begin
			// Restart discards any run in progress
			d.run  = (value_i != 16'h0000);
			d.pre  = 32'h0000_0000;
			d.cnt  = value_i;
			d.done = (value_i == 16'h0000);
		end else if (q.run) begin
			if (q.pre == TICK_CYC - 1) begin
				d.pre = 32'h0000_0000;
				d.cnt = q.cnt - 16'h0001;
				if (q.cnt == 16'h0001) begin
					d.run  = 1'b0;
					d.done = 1'b1;
				end
			end else begin
				d.pre = q.pre + 32'h0000_0001;
			end
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign done_o = q.done;

endmodule : eps_tmr

// ==== core/eps_phy_map.sv ====
// Maps the configuration word onto PHY control register defaults
`timescale 1ns/100ps
module eps_phy_map (
	// Configuration word
	input  wire logic [31:0] cfg_i,
	// PHY defaults
	output logic [1:0]       sel_o,
	output logic             hold_o,
	output logic [15:0]      cr1_o,
	output logic [15:0]      cr2_o,
	output logic [15:0]      cr3_o,
	output logic             an_en_o,
	output logic [3:0]       adv_o
);

	logic       ext;
	logic [2:0] spd;

	// Decode selection and feature bits
	always_comb begin
		sel_o = cfg_i[eps_pkg::CF_SEL_LO +: 2];
		// Unused code falls back to the on-chip PHY so one choice stays active
		if (sel_o != eps_pkg::PHY_SEL_EXT_MII && sel_o != eps_pkg::PHY_SEL_EXT_RMII) begin
			sel_o = eps_pkg::PHY_SEL_ON_CHIP;
		end
		ext    = (sel_o != eps_pkg::PHY_SEL_ON_CHIP);
		spd    = cfg_i[eps_pkg::CF_SPD_LO +: 3];
		cr1_o  = 16'h0000;
		cr2_o  = 16'h0000;
		cr3_o  = 16'h0000;
		cr1_o[eps_pkg::R1_LLR]       = cfg_i[eps_pkg::CF_LLR];
		cr1_o[eps_pkg::R1_TDR]       = cfg_i[eps_pkg::CF_TDR];
		cr1_o[eps_pkg::R1_MDIX_EN]   = cfg_i[eps_pkg::CF_MDIX_EN];
		cr1_o[eps_pkg::R1_ROB_MDIX]  = cfg_i[eps_pkg::CF_ROB_MDIX];
		cr1_o[eps_pkg::R1_FAST_MDIX] = cfg_i[eps_pkg::CF_FAST_MDIX];
		cr1_o[eps_pkg::R1_FAST_RXDV] = cfg_i[eps_pkg::CF_FAST_RXDV];
		cr1_o[eps_pkg::R1_FAN_LO +: 3] = cfg_i[eps_pkg::CF_FAN_LO +: 3];
		cr1_o[eps_pkg::R1_SPD_LO +: 3] = spd;
		cr2_o[eps_pkg::R2_NIB_DIS]   = cfg_i[eps_pkg::CF_NIB_DIS];
		cr2_o[eps_pkg::R2_RXER_IDLE] = cfg_i[eps_pkg::CF_RXER_IDLE];
		cr2_o[eps_pkg::R2_EXT_FD]    = cfg_i[eps_pkg::CF_EXT_FD];
		cr2_o[eps_pkg::R2_FAST_LUP]  = cfg_i[eps_pkg::CF_FAST_LUP];
		cr2_o[eps_pkg::R2_ISOLATE]   = cfg_i[eps_pkg::CF_ISOLATE];
		cr3_o[eps_pkg::R3_LD_RXERR]  = cfg_i[eps_pkg::CF_LD_RXERR];
		cr3_o[eps_pkg::R3_LD_SQE]    = cfg_i[eps_pkg::CF_LD_SQE];
		cr3_o[eps_pkg::R3_LD_SNR]    = cfg_i[eps_pkg::CF_LD_SNR];
		cr3_o[eps_pkg::R3_LD_ENERGY] = cfg_i[eps_pkg::CF_LD_ENERGY];
		cr3_o[eps_pkg::R3_POL_SWAP]  = cfg_i[eps_pkg::CF_POL_SWAP];
		cr3_o[eps_pkg::R3_PAIR_SWAP] = cfg_i[eps_pkg::CF_PAIR_SWAP];
		hold_o = cfg_i[eps_pkg::CF_HOLD];
		// Upper code half negotiates, lower half forces one mode
		an_en_o = spd[2];
		case (spd)
			3'b100:  adv_o = 4'b0001;
			3'b101:  adv_o = 4'b0011;
			3'b110:  adv_o = 4'b0111;
			3'b111:  adv_o = 4'b1111;
			default: adv_o = 4'b0001 << spd[1:0];
		endcase
		// External PHY: every internal feature is dropped
		if (ext) begin
			cr1_o   = 16'h0000;
			cr2_o   = 16'h0000;
			cr3_o   = 16'h0000;
			hold_o  = 1'b0;
			an_en_o = 1'b0;
			adv_o   = 4'b0000;
		end
	end

endmodule : eps_phy_map

// ==== core/eps_phy_select.sv ====
// PHY selection, MAC reset sequencing and low-power-idle control with APB registers
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module eps_phy_select #(
	parameter int unsigned MS_CYCLES = eps_pkg::MS_CYC
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic             pready_o,
	output logic [31:0]      prdata_o,
	output logic             pslverr_o,
	// PHY defaults and selection
	output logic [1:0]       phy_sel_o,
	output logic [15:0]      phy_ctrl_reg_one_o,
	output logic [15:0]      phy_ctrl_reg_two_o,
	output logic [15:0]      phy_ctrl_reg_three_o,
	output logic             phy_line_hold_o,
	output logic             phy_an_en_o,
	output logic [3:0]       phy_adv_o,
	output logic             phy_cfg_valid_o,
	// PHY link state and MII isolation
	input  wire logic        phy_link_up_i,
	input  wire logic        phy_fd100_i,
	output logic             mii_force_low_o,
	// MAC side
	output logic             mac_rst_o,
	input  wire logic        tx_idle_i,
	input  wire logic        rx_lpi_i,
	output logic             tx_lpi_o,
	output logic             tx_wake_o
);

	// Whole block state
	typedef struct packed {
		logic [31:0]     cfg;
		logic [31:0]     latched;
		logic [3:0]      rst_cnt;
		logic            rst_busy;
		logic            apply;
		logic [1:0]      sel;
		logic            hold;
		logic [15:0]     cr1;
		logic [15:0]     cr2;
		logic [15:0]     cr3;
		logic            an_en;
		logic [3:0]      adv;
		logic            cfg_valid;
		logic [15:0]     ls_ms;
		logic [15:0]     tw_us;
		logic            lpi_en;
		logic            link;
		logic            automate;
		logic [3:0]      sticky;
		eps_pkg::eps_tx_t txs;
		logic            rx_lpi;
		logic [31:0]     rdata;
	} eps_state_t;

	eps_state_t q, d;

	// Reset value of the whole state
	localparam eps_state_t RST_STATE = '{
		cfg:       eps_pkg::CFG_RST,
		latched:   eps_pkg::CFG_RST,
		rst_cnt:   4'h0,
		rst_busy:  1'b0,
		apply:     1'b1,
		sel:       eps_pkg::PHY_SEL_ON_CHIP,
		hold:      1'b0,
		cr1:       16'h0000,
		cr2:       16'h0000,
		cr3:       16'h0000,
		an_en:     1'b0,
		adv:       4'h0,
		cfg_valid: 1'b0,
		ls_ms:     eps_pkg::LS_TMR_RST,
		tw_us:     eps_pkg::TW_TMR_RST,
		lpi_en:    1'b0,
		link:      1'b0,
		automate:  1'b0,
		sticky:    4'h0,
		txs:       eps_pkg::EPS_TX_ACTIVE,
		rx_lpi:    1'b0,
		rdata:     32'h0000_0000
	};

	// Decoded defaults of the latched word
	logic [1:0]  map_sel;
	logic        map_hold;
	logic [15:0] map_cr1;
	logic [15:0] map_cr2;
	logic [15:0] map_cr3;
	logic        map_an_en;
	logic [3:0]  map_adv;

	// Bus and timer helpers
	logic        mac_rst;
	logic        acc;
	logic        wr;
	logic        rd_cs;
	logic        mapped;
	logic        ls_start;
	logic        ls_done;
	logic        tw_start;
	logic        tw_done;
	logic        tx_go;
	logic        tx_exit;
	logic [31:0] rmux;

	eps_phy_map u_map (
		.cfg_i   (q.latched),
		.sel_o   (map_sel),
		.hold_o  (map_hold),
		.cr1_o   (map_cr1),
		.cr2_o   (map_cr2),
		.cr3_o   (map_cr3),
		.an_en_o (map_an_en),
		.adv_o   (map_adv)
	);

	// Link-status timer in milliseconds
	eps_tmr #(.TICK_CYC(MS_CYCLES)) u_ls_tmr (
		.clk_i   (clk_i),
		.srst_i  (mac_rst),
		.start_i (ls_start),
		.value_i (q.ls_ms),
		.done_o  (ls_done)
	);

	// Transmit-wait timer in microseconds
	eps_tmr #(.TICK_CYC(eps_pkg::US_CYC)) u_tw_tmr (
		.clk_i   (clk_i),
		.srst_i  (mac_rst),
		.start_i (tw_start),
		.value_i (q.tw_us),
		.done_o  (tw_done)
	);

	// MAC held in reset by the pin or by a software pulse
	assign mac_rst = srst_i | q.rst_busy;

	// APB decode; zero wait states, so every access ends in its first access cycle
	assign acc    = psel_i & penable_i;
	assign wr     = acc & pwrite_i;
	assign rd_cs  = acc & ~pwrite_i & (paddr_i == eps_pkg::OFS_LPI_CS);
	assign mapped = (paddr_i == eps_pkg::OFS_PHY_CFG) | (paddr_i == eps_pkg::OFS_MAC_RST)
		| (paddr_i == eps_pkg::OFS_PHY_CR1) | (paddr_i == eps_pkg::OFS_PHY_CR2)
		| (paddr_i == eps_pkg::OFS_PHY_CR3) | (paddr_i == eps_pkg::OFS_PHY_SEL)
		| (paddr_i == eps_pkg::OFS_LPI_TMR) | (paddr_i == eps_pkg::OFS_LPI_CS)
		| (paddr_i == eps_pkg::OFS_NUM_ADDR);
	assign pready_o  = 1'b1;
	assign pslverr_o = acc & ~mapped;
	assign prdata_o  = q.rdata;

	// Transmit idle entry and exit conditions
	always_comb begin
		// Entry only once the link timer has run out and nothing is left to send
		tx_go = q.link & ls_done & tx_idle_i & (q.automate | q.lpi_en);
		// Automatic mode leaves on new data, manual mode on software command
		if (q.automate) begin
			tx_exit = ~q.link | ~tx_idle_i;
		end else begin
			tx_exit = ~q.link | ~q.lpi_en;
		end
	end

	assign ls_start = d.link & ~q.link;
	assign tw_start = (q.txs == eps_pkg::EPS_TX_LPI) & tx_exit;

	// Read multiplexer
	always_comb begin
		rmux = 32'h0000_0000;
		case (paddr_i)
			eps_pkg::OFS_PHY_CFG:  rmux = q.cfg;
			eps_pkg::OFS_MAC_RST:  rmux[0] = q.rst_busy;
			eps_pkg::OFS_PHY_CR1:  rmux[15:0] = q.cr1;
			eps_pkg::OFS_PHY_CR2:  rmux[15:0] = q.cr2;
			eps_pkg::OFS_PHY_CR3:  rmux[15:0] = q.cr3;
			eps_pkg::OFS_PHY_SEL:  rmux[3:0] = {q.cfg_valid, q.hold, q.sel};
			eps_pkg::OFS_LPI_TMR:  rmux = {q.ls_ms, q.tw_us};
			eps_pkg::OFS_LPI_CS: begin
				rmux[eps_pkg::LS_TX_ENTER +: 4] = q.sticky;
				rmux[eps_pkg::LS_TX_IN]    = (q.txs == eps_pkg::EPS_TX_LPI);
				rmux[eps_pkg::LS_RX_IN]    = q.rx_lpi;
				rmux[eps_pkg::LC_ENTER]    = q.lpi_en;
				rmux[eps_pkg::LC_LINK]     = q.link;
				rmux[eps_pkg::LC_AUTOMATE] = q.automate;
			end
			eps_pkg::OFS_NUM_ADDR: rmux[3:0] = eps_pkg::NUM_ADDR_DEF;
			default:               rmux = 32'h0000_0000;
		endcase
	end

	// Next-state logic
	always_comb begin
		d = q;
		// Read data is captured in the setup cycle and stands through the access cycle
		if (psel_i & ~penable_i & ~pwrite_i) begin
			d.rdata = rmux;
		end
		// Staging word: kept across software MAC reset, only takes effect at the next one
		if (wr & (paddr_i == eps_pkg::OFS_PHY_CFG)) begin
			d.cfg = pwdata_i;
		end
		// Software-started MAC reset; software must wait for busy to fall
		if (wr & (paddr_i == eps_pkg::OFS_MAC_RST) & pwdata_i[0] & ~q.rst_busy) begin
			d.rst_busy = 1'b1;
			d.rst_cnt  = eps_pkg::MAC_RST_LEN;
		end else if (q.rst_busy) begin
			d.rst_cnt = q.rst_cnt - 4'h1;
			if (q.rst_cnt == 4'h1) begin
				d.rst_busy = 1'b0;
			end
		end
		// Timer values
		if (wr & (paddr_i == eps_pkg::OFS_LPI_TMR)) begin
			d.ls_ms = pwdata_i[31:16];
			d.tw_us = pwdata_i[15:0];
		end
		// Control bits of the idle register
		if (wr & (paddr_i == eps_pkg::OFS_LPI_CS)) begin
			d.lpi_en   = pwdata_i[eps_pkg::LC_ENTER];
			d.link     = pwdata_i[eps_pkg::LC_LINK];
			d.automate = pwdata_i[eps_pkg::LC_AUTOMATE];
		end
		// Transmit idle state machine
		case (q.txs)
			eps_pkg::EPS_TX_ACTIVE: begin
				if (tx_go) begin
					d.txs = eps_pkg::EPS_TX_LPI;
				end
			end
			eps_pkg::EPS_TX_LPI: begin
				if (tx_exit) begin
					d.txs = eps_pkg::EPS_TX_WAKE;
				end
			end
			eps_pkg::EPS_TX_WAKE: begin
				// Data held off until the wake wait has passed
				if (tw_done) begin
					d.txs = eps_pkg::EPS_TX_ACTIVE;
				end
			end
			default: d.txs = eps_pkg::EPS_TX_ACTIVE;
		endcase
		d.rx_lpi = rx_lpi_i;
		// Sticky events clear on read, but an event in the same cycle survives
		if (rd_cs) begin
			d.sticky = 4'h0;
		end
		d.sticky[eps_pkg::LS_TX_ENTER] = d.sticky[eps_pkg::LS_TX_ENTER] | (tx_go & (q.txs == eps_pkg::EPS_TX_ACTIVE));
		d.sticky[eps_pkg::LS_TX_EXIT]  = d.sticky[eps_pkg::LS_TX_EXIT] | tw_start;
		d.sticky[eps_pkg::LS_RX_ENTER] = d.sticky[eps_pkg::LS_RX_ENTER] | (rx_lpi_i & ~q.rx_lpi);
		d.sticky[eps_pkg::LS_RX_EXIT]  = d.sticky[eps_pkg::LS_RX_EXIT] | (~rx_lpi_i & q.rx_lpi);
		// Defaults are transferred to the PHY right after reset release, and each cycle from the second cycle of a software MAC reset to the cycle after it
		if (q.apply) begin
			d.apply     = 1'b0;
			d.sel       = map_sel;
			d.hold      = map_hold;
			d.cr1       = map_cr1;
			d.cr2       = map_cr2;
			d.cr3       = map_cr3;
			d.an_en     = map_an_en;
			d.adv       = map_adv;
			d.cfg_valid = 1'b1;
		end
		// During MAC reset: sample selection, drop all MAC configuration
		if (q.rst_busy) begin
			d.latched   = q.cfg;
			d.apply     = 1'b1;
			d.cfg_valid = 1'b0;
			d.ls_ms     = eps_pkg::LS_TMR_RST;
			d.tw_us     = eps_pkg::TW_TMR_RST;
			d.lpi_en    = 1'b0;
			d.link      = 1'b0;
			d.automate  = 1'b0;
			d.sticky    = 4'h0;
			d.txs       = eps_pkg::EPS_TX_ACTIVE;
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			q <= RST_STATE;
		end else begin
			q <= d;
		end
	end

	// PHY side outputs, all from flip-flops
	assign phy_sel_o            = q.sel;
	assign phy_ctrl_reg_one_o   = q.cr1;
	assign phy_ctrl_reg_two_o   = q.cr2;
	assign phy_ctrl_reg_three_o = q.cr3;
	assign phy_line_hold_o      = q.hold;
	assign phy_an_en_o          = q.an_en;
	assign phy_adv_o            = q.adv;
	assign phy_cfg_valid_o      = q.cfg_valid;

	// Outputs tied low until a 100 Mb/s full-duplex link exists
	assign mii_force_low_o = q.cr2[eps_pkg::R2_ISOLATE] & ~(phy_link_up_i & phy_fd100_i);

	// MAC side outputs
	assign mac_rst_o = mac_rst;
	assign tx_lpi_o  = (q.txs == eps_pkg::EPS_TX_LPI);
	assign tx_wake_o = (q.txs == eps_pkg::EPS_TX_WAKE);

endmodule : eps_phy_select

// ==== testbench/eps_phy_select_properties.sv ====
// Checker for the PHY select block, watching only its ports
`timescale 1ns/100ps
module eps_phy_select_properties (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        srst_i,
	// APB
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pslverr_o,
	// PHY side
	input wire logic [1:0]  phy_sel_o,
	input wire logic [15:0] phy_ctrl_reg_one_o,
	input wire logic [15:0] phy_ctrl_reg_two_o,
	input wire logic [15:0] phy_ctrl_reg_three_o,
	input wire logic        phy_line_hold_o,
	input wire logic        phy_an_en_o,
	input wire logic [3:0]  phy_adv_o,
	input wire logic        phy_cfg_valid_o,
	input wire logic        phy_link_up_i,
	input wire logic        phy_fd100_i,
	input wire logic        mii_force_low_o,
	// MAC side
	input wire logic        mac_rst_o,
	input wire logic        tx_idle_i,
	input wire logic        tx_lpi_o
);
	// One clock domain, so one clocking and one disable for all
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	a_sel_legal: assert property (phy_sel_o != 2'h3) else $error("illegal selection");
	a_sel_held: assert property (!mac_rst_o && !$past(mac_rst_o) && !$past(mac_rst_o, 2)
		|-> $stable(phy_sel_o) && $stable(phy_ctrl_reg_one_o)) else $error("sel moved");
	a_ext_zero: assert property (phy_sel_o inside {2'h1, 2'h2} |->
		phy_ctrl_reg_one_o == 16'h0 && phy_ctrl_reg_two_o == 16'h0
		&& phy_ctrl_reg_three_o == 16'h0 && !phy_line_hold_o)
		else $error("external kept internal settings");
	a_mii_isolate: assert property (mii_force_low_o == (phy_ctrl_reg_two_o[3]
		&& !(phy_link_up_i && phy_fd100_i))) else $error("isolate wrong");
	a_adv_cumul: assert property (phy_an_en_o |-> phy_ctrl_reg_one_o[13] &&
		phy_adv_o == (4'hF >> (2'd3 - phy_ctrl_reg_one_o[12:11]))) else $error("adv wrong");
	a_adv_forced: assert property (phy_cfg_valid_o && phy_sel_o == 2'h0 && !phy_an_en_o
		|-> phy_adv_o == (4'h1 << phy_ctrl_reg_one_o[12:11])) else $error("forced wrong");
	a_rst_len: assert property ($rose(mac_rst_o) |-> mac_rst_o [*8])
		else $error("short reset");
	a_valid_after: assert property ($fell(mac_rst_o) |-> ##[0:2] phy_cfg_valid_o)
		else $error("defaults not applied");
	a_lpi_idle: assert property ($rose(tx_lpi_o) |-> $past(tx_idle_i))
		else $error("lpi busy");
	a_err_access: assert property (pslverr_o |-> psel_i && penable_i) else $error("stray err");
endmodule : eps_phy_select_properties

// ==== testbench/eps_phy_model.sv ====
// Behavioural PHY: link state and receive idle towards the block
`timescale 1ns/100ps
module eps_phy_model (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic srst_i,
	// Scenario control
	input  wire logic link_req_i,
	input  wire logic fd_req_i,
	// Towards the block
	output logic      link_up_o,
	output logic      fd100_o,
	output logic      rx_lpi_o
);
	// Link follows the request a cycle late; receive idle wanders only with link up
	always_ff @(posedge clk_i) begin
		link_up_o <= !srst_i && link_req_i;
		fd100_o   <= !srst_i && fd_req_i;
		rx_lpi_o  <= link_up_o && $urandom_range(0, 1) == 0;
	end
endmodule : eps_phy_model

// ==== testbench/test_eps_phy_select.sv ====
// Self-checking bench for the PHY select block
`timescale 1ns/100ps
module test_eps_phy_select;
	// Stimulus
	logic        clk_i = 0, srst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic        tx_idle_i = 0, link_req = 0, fd_req = 0, err;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0000_0000, rd, cfg;
	logic [1:0]  sel_exp;
	int          error_cnt = 0, checks = 0;
	// Design outputs
	logic        pready_o, pslverr_o, hold, an_en, valid, isol, mac_rst, lpi, wake;
	logic        link_up, fd100, rx_lpi;
	logic [31:0] prdata_o;
	logic [1:0]  phy_sel;
	logic [15:0] cr1, cr2, cr3;
	logic [3:0]  adv;

	always #2 clk_i = ~clk_i;

	eps_phy_select #(.MS_CYCLES(10)) eps_phy_select_inst (.clk_i(clk_i), .srst_i(srst_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
		.phy_sel_o(phy_sel), .phy_ctrl_reg_one_o(cr1), .phy_ctrl_reg_two_o(cr2),
		.phy_ctrl_reg_three_o(cr3), .phy_line_hold_o(hold), .phy_an_en_o(an_en),
		.phy_adv_o(adv), .phy_cfg_valid_o(valid), .phy_link_up_i(link_up),
		.phy_fd100_i(fd100), .mii_force_low_o(isol), .mac_rst_o(mac_rst),
		.tx_idle_i(tx_idle_i), .rx_lpi_i(rx_lpi), .tx_lpi_o(lpi), .tx_wake_o(wake));
	eps_phy_model eps_phy_model_inst (.clk_i(clk_i), .srst_i(srst_i), .link_req_i(link_req),
		.fd_req_i(fd_req), .link_up_o(link_up), .fd100_o(fd100), .rx_lpi_o(rx_lpi));

	// Compare and count
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Verdict and end of run
	task report_and_stop;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : report_and_stop

	// One APB transfer; holds the request until pready is seen high
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		psel_i <= 1; penable_i <= 0; pwrite_i <= wr; paddr_i <= a; pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1;
		n = 0;
		do @(posedge clk_i); while (pready_o !== 1'b1 && ++n < 16);
		if (n >= 16) error_cnt++;
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 0; penable_i <= 0;
	endtask : apb

	// Soft MAC reset, poll busy, then wait for the defaults to land
	task mac_reset;
		int n;
		apb(1, eps_pkg::OFS_MAC_RST, 32'h0000_0001);
		n = 0;
		do apb(0, eps_pkg::OFS_MAC_RST, 0); while (rd[0] !== 1'b0 && ++n < 20);
		n = 0;
		while (valid !== 1'b1 && n++ < 10) @(posedge clk_i);
	endtask : mac_reset

	// Expected control words from the configuration word
	function automatic logic [47:0] exp_regs(input logic [31:0] c);
		if (c[1:0] == eps_pkg::PHY_SEL_EXT_MII || c[1:0] == eps_pkg::PHY_SEL_EXT_RMII) return 48'h0;
		return {9'h0, c[25], c[24], 1'b0, c[20], c[21], c[22], c[23],
			9'h0, c[7], c[6], 1'b0, c[5], c[4], c[3], 1'b0,
			1'b0, c[12], c[19:17], 2'b0, c[9], c[8], c[11], c[10], c[16:14], c[13], 1'b0};
	endfunction : exp_regs

	// Watchdog
	initial begin
		#400000;
		error_cnt++;
		report_and_stop();
	end

	// Wait up to n cycles for the idle output to reach a level
	task wait_lpi(input logic v, input int n);
		while (lpi !== v && n-- > 0) @(posedge clk_i);
	endtask : wait_lpi

	initial begin
		void'($urandom(32'hf0e64c6a));
		repeat (5) @(posedge clk_i);
		srst_i <= 0;
		apb(0, eps_pkg::OFS_LPI_TMR, 0);
		check(rd, 32'h03E8_0000);
		apb(0, eps_pkg::OFS_NUM_ADDR, 0);
		check(rd, 32'h0000_0004);
		apb(0, eps_pkg::OFS_PHY_SEL, 0);
		check(rd, 32'h0000_0008);
		apb(0, 12'h024, 0);
		check({rd[30:0], err}, 32'h0000_0001);
		apb(0, 12'h002, 0);
		check({31'h0, err}, 32'h0000_0001);
		sel_exp = 2'h0;
		// Random configurations, corner word first, every selection code incl. unused 3
		for (int i = 0; i < 9; i++) begin
			cfg = {6'h0, 26'($urandom())};
			if (i == 0) cfg = 32'h03FF_FFFF;
			cfg[1:0] = 2'(i % 4);
			apb(1, eps_pkg::OFS_PHY_CFG, cfg);
			apb(1, eps_pkg::OFS_LPI_TMR, 32'h0005_0007);
			check(phy_sel, sel_exp);
			mac_reset();
			// Unused code 3 falls back to the on-chip PHY
			sel_exp = (cfg[1:0] == 2'h3) ? eps_pkg::PHY_SEL_ON_CHIP : cfg[1:0];
			check(phy_sel, sel_exp);
			check({cr3, cr2, cr1}, exp_regs(cfg));
			check(hold, cfg[2] && sel_exp == eps_pkg::PHY_SEL_ON_CHIP);
			apb(0, eps_pkg::OFS_PHY_CR1, 0);
			check(rd, {16'h0, exp_regs(cfg)[15:0]});
			apb(0, eps_pkg::OFS_LPI_TMR, 0);
			check(rd, 32'h03E8_0000);
		end
		// Isolation of the MII outputs against link state
		apb(1, eps_pkg::OFS_PHY_CFG, 32'h0000_0020);
		mac_reset();
		repeat (3) @(posedge clk_i);
		check(isol, 1);
		link_req <= 1; fd_req <= 1;
		repeat (3) @(posedge clk_i);
		check(isol, 0);
		// Automatic idle entry and exit
		apb(1, eps_pkg::OFS_LPI_TMR, 32'h0001_0000);
		tx_idle_i <= 1;
		apb(1, eps_pkg::OFS_LPI_CS, 32'h000A_0000);
		wait_lpi(1, 40);
		check(lpi, 1);
		apb(0, eps_pkg::OFS_LPI_CS, 0);
		// Receive idle wanders at random, so only the transmit bits are compared
		check({rd[8], rd[1:0]}, 3'b101);
		tx_idle_i <= 0;
		wait_lpi(0, 10);
		check(lpi, 0);
		// Manual mode waits for the request bit
		tx_idle_i <= 1;
		apb(1, eps_pkg::OFS_LPI_CS, 32'h0002_0000);
		repeat (30) @(posedge clk_i);
		check(lpi, 0);
		apb(1, eps_pkg::OFS_LPI_CS, 32'h0003_0000);
		wait_lpi(1, 10);
		check(lpi, 1);
		apb(1, eps_pkg::OFS_LPI_CS, 32'h0001_0000);
		wait_lpi(0, 10);
		check(lpi, 0);
		report_and_stop();
	end
endmodule : test_eps_phy_select

bind eps_phy_select eps_phy_select_properties eps_phy_select_properties_inst (.clk_i(clk_i),
	.srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i), .pslverr_o(pslverr_o),
	.phy_sel_o(phy_sel_o), .phy_ctrl_reg_one_o(phy_ctrl_reg_one_o),
	.phy_ctrl_reg_two_o(phy_ctrl_reg_two_o), .phy_ctrl_reg_three_o(phy_ctrl_reg_three_o),
	.phy_line_hold_o(phy_line_hold_o), .phy_an_en_o(phy_an_en_o), .phy_adv_o(phy_adv_o),
	.phy_cfg_valid_o(phy_cfg_valid_o), .phy_link_up_i(phy_link_up_i),
	.phy_fd100_i(phy_fd100_i), .mii_force_low_o(mii_force_low_o), .mac_rst_o(mac_rst_o),
	.tx_idle_i(tx_idle_i), .tx_lpi_o(tx_lpi_o));
